// [shared/hub_seq_pkg.sv]
// Constants, register map and stage type for the hub mode stage sequencer.
// Assumes a 10 MHz system clock; all times are turned into cycle counts here.
package hub_seq_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_HZ = 10_000_000;          // System clock rate.
   localparam int HUB_INIT_MS = 3;              // Init interval, typical.
   localparam int HUB_CONFIG_MS = 400;          // Setup time-out, typical.
   localparam int HUB_CONNECT_US = 1;           // Connect interval, typical.
   localparam int HUB_INIT_CYC = HUB_INIT_MS * (CLK_HZ / 1000);
   localparam int HUB_CONFIG_CYC = HUB_CONFIG_MS * (CLK_HZ / 1000);
   localparam int HUB_CONNECT_CYC = HUB_CONNECT_US * (CLK_HZ / 1_000_000);
   localparam int TIMER_W = 23;                 // Wide enough for the time-out.

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_INTERLOCK = 8'h00; // stage_interlock_register.
   localparam logic [7:0] ADDR_SETUP = 8'h04;     // portable_setup_register.
   localparam logic [7:0] ADDR_STATUS = 8'h08;    // Read-only stage status.

   // Field positions.
   localparam int BIT_HOLD_SETUP = 0;           // Interlock: hold in setup.
   localparam int BIT_CONNECT_GO = 1;           // Interlock: connect handshake.
   localparam int BIT_CHG_EN = 0;               // Setup: charger detect enable.
   localparam int BIT_CONN_WAIT = 1;            // Setup: wait in connect.
   localparam int BIT_CHG_DONE = 8;             // Status: detection completed.
   localparam int BIT_CHG_ABORT = 9;            // Status: detection aborted.

   // Defaults held in the internal ROM.
   localparam logic ROM_HOLD_SETUP = 1'b0;
   localparam logic ROM_CHG_EN = 1'b1;
   localparam logic ROM_CONN_WAIT = 1'b0;

   // ****************************************************************
   // Operating mode and hub stages
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_STANDBY, ST_BYPASS, ST_INIT, ST_WAIT_CLK,
      ST_CONFIG, ST_CHG_DET, ST_CONNECT, ST_COMM
   } stage_t;

endpackage

// [rtl/hub_mode_stage_sequencer.sv]
// Mode and hub stage sequencer with an APB register port.
// Assumes pins arrive asynchronously and an analog charger detector
// answers the run request with a one-cycle done pulse on this clock.
//
// What this block does
// - Two pins choose standby, bypass or hub.
// - Standby powers everything off, loses configuration.
// - Reset pin low: ports off, registers default.
// - Init stage loads ROM defaults.
// - Bypass stops regulator, PLL, core; loses configuration.
// - Hub mode: switch off, stages in order.
// - Init enables regulator, PLL, latches strap pins.
// - Init ends after interval; port ignored.
// - Wait stage proceeds once reference clock active and PLL locked.
// - No clock, detection enabled: run on oscillator.
// - PLL lock aborts oscillator detection, no result.
// - Port ignored in wait-for-clock stage.
// - Clock present and PLL locked at entry skips wait stage.
// - Hold bit low unwritten: advance after time-out.
// - Hold bit high: stay until written low.
// - Detection disabled skips; else run then connect.
// - Connect: pull-up at once or await handshake.
// - Handshake: pull-up on, connect, then communicate.
// - Communication stage: no port; leave by pins.
// - Unwritten registers keep their defaults.
`timescale 1ns/100ps
module hub_mode_stage_sequencer
   import hub_seq_pkg::*;
#(
   parameter logic [TIMER_W-1:0] INIT_CYC = TIMER_W'(HUB_INIT_CYC),
   parameter logic [TIMER_W-1:0] CONFIG_CYC = TIMER_W'(HUB_CONFIG_CYC)
) (
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   // Mode pins and analog status, asynchronous.
   input wire logic i_hard_reset_pin_n,
   input wire logic i_pass_select_pin_n,
   input wire logic i_ref_clk_active,
   input wire logic i_pll_locked,
   input wire logic [1:0] i_ref_sel_pins,
   input wire logic [1:0] i_bus_addr_select_pins,
   // Charger detector answer, same clock.
   input wire logic i_chg_det_done,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata,
   // Power, switch and link controls.
   output logic o_ldo_1v2_en,
   output logic o_pll_run,
   output logic o_core_power_on,
   output logic o_bypass_switch_on,
   output logic o_ports_enable,
   output logic o_upstream_dplus_pin,
   output logic o_chg_det_run,
   output logic o_ring_osc_sel,
   output logic o_rom_load,
   output logic [2:0] o_stage
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [7:0] sync1_reg; // First stage, read only by the second.
   logic [7:0] sync2_reg; // Settled copies.
   logic rst_pin_n, pass_pin_n, ref_act, pll_lk;

   // Two flops on every asynchronous input before logic reads it.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end else begin
         sync1_reg <= {i_bus_addr_select_pins, i_ref_sel_pins, i_pll_locked,
                       i_ref_clk_active, i_pass_select_pin_n, i_hard_reset_pin_n};
         sync2_reg <= sync1_reg;
      end
   end
   assign rst_pin_n = sync2_reg[0];
   assign pass_pin_n = sync2_reg[1];
   assign ref_act = sync2_reg[2];
   assign pll_lk = sync2_reg[3];

   // ****************************************************************
   // Stage state
   // ****************************************************************
   stage_t stage_reg;              // Current mode or hub stage.
   logic [TIMER_W-1:0] timer_reg;  // Cycles spent in the timed stage.
   logic hold_reg, go_reg;         // Interlock fields.
   logic chg_en_reg, wait_en_reg;  // Setup fields.
   logic hold_seen_reg;            // Hold bit was high during setup.
   logic clk_early_reg;            // Clock active in the last cycle of init.
   logic chg_done_reg, chg_abort_reg;
   logic pullup_reg;
   logic [3:0] straps_reg;         // Latched select pins.
   logic hub_sel, port_open, acc, wr;

   // Mode from the two pins: reset low is standby, then pass low is bypass.
   assign hub_sel = rst_pin_n && pass_pin_n;

   // The port is served only while configuring or awaiting the handshake.
   assign port_open = (stage_reg == ST_CONFIG) || (stage_reg == ST_CONNECT);
   assign acc = i_psel && i_penable;
   assign wr = acc && i_pwrite && port_open;

   // Mode selection and hub stage progression.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         stage_reg <= ST_STANDBY;
         timer_reg <= '0;
      end else if (!rst_pin_n) begin
         stage_reg <= ST_STANDBY;
         timer_reg <= '0;
      end else if (!pass_pin_n) begin
         stage_reg <= ST_BYPASS;
         timer_reg <= '0;
      end else begin
         timer_reg <= timer_reg + 1'b1;
         unique case (stage_reg)
            // Entering hub mode always starts with init.
            ST_STANDBY, ST_BYPASS: begin
               stage_reg <= ST_INIT;
               timer_reg <= '0;
            end
            // Init leaves on its own after the interval.
            ST_INIT: begin
               if (timer_reg >= INIT_CYC - 1'b1) begin
                  stage_reg <= (clk_early_reg && pll_lk) ? ST_CONFIG : ST_WAIT_CLK;
                  timer_reg <= '0;
               end
            end
            // Wait for an active reference clock and PLL lock.
            ST_WAIT_CLK: begin
               if (ref_act && pll_lk) begin
                  stage_reg <= ST_CONFIG;
                  timer_reg <= '0;
               end
            end
            // Time-out applies only while hold has never been high.
            ST_CONFIG: begin
               if (!hold_reg && (hold_seen_reg || timer_reg >= CONFIG_CYC - 1'b1)) begin
                  stage_reg <= ST_CHG_DET;
                  timer_reg <= '0;
               end
            end
            // Skip when disabled, else wait for the detector.
            ST_CHG_DET: begin
               if (!chg_en_reg || i_chg_det_done) begin
                  stage_reg <= ST_CONNECT;
                  timer_reg <= '0;
               end
            end
            // Hold the count at zero until the pull-up is on.
            ST_CONNECT: begin
               if (!pullup_reg) begin
                  timer_reg <= '0;
               end else if (timer_reg >= TIMER_W'(HUB_CONNECT_CYC) - 1'b1) begin
                  stage_reg <= ST_COMM;
               end
            end
            // Only the mode pins end communication.
            ST_COMM: begin
               timer_reg <= '0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Registers reachable over the port
   // ****************************************************************
   // Outside hub mode and during init everything returns to ROM defaults.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         hold_reg <= ROM_HOLD_SETUP;
         go_reg <= 1'b0;
         chg_en_reg <= ROM_CHG_EN;
         wait_en_reg <= ROM_CONN_WAIT;
      end else if (!hub_sel || stage_reg == ST_INIT) begin
         hold_reg <= ROM_HOLD_SETUP;
         go_reg <= 1'b0;
         chg_en_reg <= ROM_CHG_EN;
         wait_en_reg <= ROM_CONN_WAIT;
      end else if (wr && i_paddr == ADDR_INTERLOCK) begin
         hold_reg <= i_pwdata[BIT_HOLD_SETUP];
         go_reg <= i_pwdata[BIT_CONNECT_GO] && stage_reg == ST_CONNECT;
      end else if (wr && i_paddr == ADDR_SETUP) begin
         chg_en_reg <= i_pwdata[BIT_CHG_EN];
         wait_en_reg <= i_pwdata[BIT_CONN_WAIT];
      end
   end

   // Hold bit history and pull-up, both cleared outside the hub stages.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n || !hub_sel) begin
         hold_seen_reg <= 1'b0;
         pullup_reg <= 1'b0;
      end else begin
         if (stage_reg == ST_CONFIG && hold_reg)
            hold_seen_reg <= 1'b1;
         if (stage_reg == ST_CONNECT && (go_reg || !wait_en_reg))
            pullup_reg <= 1'b1;
      end
   end

   // Straps and the early clock check are caught during init.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         straps_reg <= 4'h0;
         clk_early_reg <= 1'b0;
      end else if (stage_reg == ST_INIT) begin
         straps_reg <= sync2_reg[7:4];
         clk_early_reg <= ref_act;
      end
   end

   // Oscillator-clocked detection while the reference clock is missing.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n || !hub_sel || stage_reg == ST_INIT) begin
         chg_done_reg <= 1'b0;
         chg_abort_reg <= 1'b0;
      end else if (o_ring_osc_sel && pll_lk) begin
         chg_abort_reg <= 1'b1;
      end else if (o_chg_det_run && i_chg_det_done) begin
         chg_done_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // APB answer
   // ****************************************************************
   logic [31:0] rd_data;
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (i_paddr)
         ADDR_INTERLOCK: rd_data[BIT_HOLD_SETUP] = hold_reg;
         ADDR_SETUP: rd_data = {30'h0, wait_en_reg, chg_en_reg};
         ADDR_STATUS: rd_data = {22'h0, chg_abort_reg, chg_done_reg, straps_reg,
                                 1'b0, stage_reg};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Read data is captured in the setup cycle; blocked reads return zero.
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_prdata <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (i_psel && !i_penable) begin
         o_prdata <= port_open ? rd_data : 32'h0000_0000;
         o_pslverr <= !port_open || (i_paddr != ADDR_INTERLOCK &&
                      i_paddr != ADDR_SETUP && i_paddr != ADDR_STATUS);
      end
   end
   assign o_pready = 1'b1; // Zero wait states.

   // ****************************************************************
   // Power, switch and link outputs
   // ****************************************************************
   logic in_hub;
   assign in_hub = stage_reg != ST_STANDBY && stage_reg != ST_BYPASS;
   assign o_ldo_1v2_en = in_hub;
   assign o_pll_run = in_hub;
   assign o_core_power_on = in_hub;
   assign o_bypass_switch_on = stage_reg == ST_BYPASS;
   assign o_ports_enable = stage_reg == ST_COMM;
   assign o_upstream_dplus_pin = pullup_reg;
   assign o_ring_osc_sel = stage_reg == ST_WAIT_CLK && !ref_act && chg_en_reg
                           && !chg_abort_reg && !chg_done_reg;
   assign o_chg_det_run = o_ring_osc_sel || (stage_reg == ST_CHG_DET && chg_en_reg);
   assign o_rom_load = stage_reg == ST_INIT;
   assign o_stage = stage_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);

   sequence s_pins_standby;
      !rst_pin_n;
   endsequence
   sequence s_go_hub;
      hub_sel && stage_reg == ST_CONNECT && go_reg;
   endsequence

   chk_standby_pin: assert property (s_pins_standby |=> stage_reg == ST_STANDBY)
      else $error("Reset pin low did not give standby.");
   chk_bypass_pin: assert property (rst_pin_n && !pass_pin_n |=> o_bypass_switch_on)
      else $error("Bypass pins did not close the switch.");
   chk_power_off: assert property (stage_reg == ST_STANDBY |-> !o_ldo_1v2_en && !o_pll_run
                                   && !o_ports_enable)
      else $error("Power left on in standby.");
   chk_defaults_back: assert property (!hub_sel |=> hold_reg == ROM_HOLD_SETUP
                                       && chg_en_reg == ROM_CHG_EN)
      else $error("Registers not back at defaults.");
   chk_hub_entry: assert property (hub_sel && (stage_reg == ST_STANDBY ||
                                   stage_reg == ST_BYPASS) |=> stage_reg == ST_INIT)
      else $error("Hub entry did not begin with init.");
   chk_init_len: assert property (hub_sel && $changed(stage_reg) && stage_reg == ST_INIT
                                  |-> timer_reg == '0)
      else $error("Init timer not cleared on entry.");
   chk_port_closed: assert property (i_psel && !i_penable && !port_open |=> o_pslverr
                                     && o_prdata == 32'h0000_0000)
      else $error("Closed port answered a read.");
   chk_chg_skip: assert property (hub_sel && stage_reg == ST_CHG_DET && !chg_en_reg
                                  |=> stage_reg == ST_CONNECT)
      else $error("Disabled detection did not skip.");
   chk_abort_osc: assert property (hub_sel && o_ring_osc_sel && pll_lk |=> chg_abort_reg
                                   && !o_ring_osc_sel)
      else $error("Lock did not abort oscillator detection.");
   chk_hold_stays: assert property (hub_sel && stage_reg == ST_CONFIG && hold_reg
                                    |=> stage_reg == ST_CONFIG)
      else $error("Left setup while held.");
   chk_connect_go: assert property (s_go_hub |=> pullup_reg ##[1:10]
                                    (stage_reg == ST_COMM || !hub_sel))
      else $error("Handshake did not connect in time.");
   chk_comm_sticky: assert property (hub_sel && stage_reg == ST_COMM |=> stage_reg == ST_COMM
                                     || !hub_sel)
      else $error("Communication left without the pins.");

endmodule // hub_mode_stage_sequencer

// [tb/chg_det_model.sv]
// Behavioural charger detector that answers the sequencer's run request.
// Assumes the sequencer clock and a level run request; delay set by the bench.
`timescale 1ns/100ps
module chg_det_model (
   // Clock and request.
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic [7:0] i_delay,
   // Completion pulse.
   output logic o_done
);
   logic [7:0] cnt = 8'h00; // Cycles spent in the current run.
   // Count while the run lasts and pulse once; a dropped run restarts it.
   always_ff @(posedge i_clk) begin
      o_done <= 1'b0;
      if (!i_run) begin
         cnt <= 8'h00;
      end else if (cnt != 8'hff) begin
         cnt <= cnt + 8'h01;
         o_done <= (cnt == i_delay);
      end
   end
endmodule // chg_det_model

// [tb/hub_mode_stage_sequencer_tb.sv]
// Self-checking bench for the hub mode stage sequencer.
// Assumes short init and setup counts and a behavioural charger detector.
`timescale 1ns/100ps
module hub_mode_stage_sequencer_tb;
   import hub_seq_pkg::*;
   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   localparam int INIT_N = 20; // Shortened init interval.
   localparam int CFG_N = 50; // Shortened setup time-out.
   localparam int RST_HOLD_N = 1000; // Pin reset held 100 us at 10 MHz.
   logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_hard_reset_pin_n = 1'b0;
   logic i_pass_select_pin_n = 1'b1, i_ref_clk_active = 1'b1, i_pll_locked = 1'b1;
   logic [1:0] i_ref_sel_pins = 2'b10, i_bus_addr_select_pins = 2'b01;
   logic i_chg_det_done, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00, det_delay = 8'h05;
   logic [31:0] i_pwdata = 32'h0, o_prdata, rnd = 32'h17;
   logic o_pready, o_pslverr, o_ldo_1v2_en, o_pll_run, o_core_power_on, o_bypass_switch_on;
   logic o_ports_enable, o_upstream_dplus_pin, o_chg_det_run, o_ring_osc_sel, o_rom_load;
   logic [2:0] o_stage;
   logic [33:0] notes[$]; // Expected {is_read, error, data} per transfer.
   int mismatches = 0, n_compared = 0;
   always #50 i_clk_sys = ~i_clk_sys;
   hub_mode_stage_sequencer #(.INIT_CYC(TIMER_W'(INIT_N)), .CONFIG_CYC(TIMER_W'(CFG_N))) uut (
      .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_hard_reset_pin_n(i_hard_reset_pin_n),
      .i_pass_select_pin_n(i_pass_select_pin_n), .i_ref_clk_active(i_ref_clk_active),
      .i_pll_locked(i_pll_locked), .i_ref_sel_pins(i_ref_sel_pins),
      .i_bus_addr_select_pins(i_bus_addr_select_pins), .i_chg_det_done(i_chg_det_done),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
      .o_ldo_1v2_en(o_ldo_1v2_en), .o_pll_run(o_pll_run), .o_core_power_on(o_core_power_on),
      .o_bypass_switch_on(o_bypass_switch_on), .o_ports_enable(o_ports_enable),
      .o_upstream_dplus_pin(o_upstream_dplus_pin), .o_chg_det_run(o_chg_det_run),
      .o_ring_osc_sel(o_ring_osc_sel), .o_rom_load(o_rom_load), .o_stage(o_stage));
   chg_det_model det (.i_clk(i_clk_sys), .i_run(o_chg_det_run), .i_delay(det_delay),
      .o_done(i_chg_det_done));
   // ****************************************************************
   // Checking tasks
   // ****************************************************************
   // Compares one value and counts the result.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic tally_and_finish();
      if (mismatches == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Steps the random source used for unused write bits.
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // One APB transfer: setup, then access held until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] exp_d, input logic exp_e);
      notes.push_back({~wr, exp_e, exp_d});
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      @(posedge i_clk_sys);
      while (o_pready !== 1'b1) begin
         @(posedge i_clk_sys);
      end
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      // An idle edge keeps the next request from reassigning psel in this step.
      @(posedge i_clk_sys);
   endtask
   // Takes the oldest note whenever an access completes and compares it.
   always @(posedge i_clk_sys) begin
      logic [33:0] nt;
      if (i_psel && i_penable && o_pready === 1'b1 && notes.size() > 0) begin
         nt = notes.pop_front();
         check({31'h0, o_pslverr}, {31'h0, nt[32]});
         if (nt[33]) check(o_prdata, nt[31:0]);
      end
   end
   // Waits a bounded time for a stage, then compares it.
   task automatic wait_stage(input stage_t s, input int lim);
      int n;
      n = 0;
      while (o_stage !== s && n < lim) begin
         @(posedge i_clk_sys);
         n++;
      end
      check(32'(o_stage), 32'(s));
   endtask
   // Writes a register with random unused upper bits.
   task automatic wr(input logic [7:0] a, input logic [1:0] v, input logic e);
      rnd = lfsr_next(rnd);
      apb(1'b1, a, {rnd[31:2], v}, 32'h0, e);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      repeat (2) @(posedge i_clk_sys);
      i_reset_n <= 1'b1;
      @(posedge i_clk_sys);
      check({o_stage, o_ldo_1v2_en, o_pll_run, o_ports_enable, o_pready},
            {3'(ST_STANDBY), 4'b0001});
      repeat (RST_HOLD_N) @(posedge i_clk_sys);
      i_hard_reset_pin_n <= 1'b1;
      wait_stage(ST_INIT, 10);
      check({o_rom_load, o_ldo_1v2_en, o_pll_run, o_bypass_switch_on}, 4'b1110);
      apb(1'b0, ADDR_STATUS, 32'h0, 32'h0, 1'b1);
      wait_stage(ST_CONFIG, INIT_N + 10);
      apb(1'b0, ADDR_STATUS, 32'h0, 32'h64, 1'b0);
      apb(1'b0, ADDR_SETUP, 32'h0, 32'h1, 1'b0);
      apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
      wr(ADDR_INTERLOCK, 2'b01, 1'b0);
      apb(1'b0, ADDR_INTERLOCK, 32'h0, 32'h1, 1'b0);
      repeat (CFG_N + 10) @(posedge i_clk_sys);
      check(32'(o_stage), 32'(ST_CONFIG));
      wr(ADDR_INTERLOCK, 2'b00, 1'b0);
      wait_stage(ST_CHG_DET, 10);
      check({31'h0, o_chg_det_run}, 32'h1);
      wait_stage(ST_CONNECT, 20);
      wait_stage(ST_COMM, 20);
      check({o_upstream_dplus_pin, o_ports_enable}, 2'b11);
      apb(1'b0, ADDR_SETUP, 32'h0, 32'h0, 1'b1);
      i_hard_reset_pin_n <= 1'b0;
      wait_stage(ST_STANDBY, 10);
      check({o_ports_enable, o_ldo_1v2_en, o_core_power_on}, 3'b000);
      repeat (RST_HOLD_N) @(posedge i_clk_sys);
      i_hard_reset_pin_n <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_pass_select_pin_n <= 1'b0;
      wait_stage(ST_BYPASS, 10);
      check({o_bypass_switch_on, o_ldo_1v2_en, o_pll_run, o_core_power_on}, 4'b1000);
      {i_ref_clk_active, i_pll_locked, det_delay} <= {2'b00, 8'hc8};
      i_pass_select_pin_n <= 1'b1;
      wait_stage(ST_WAIT_CLK, INIT_N + 20);
      check({o_ring_osc_sel, o_chg_det_run}, 2'b11);
      apb(1'b0, ADDR_SETUP, 32'h0, 32'h0, 1'b1);
      // Lock arrives first so the oscillator run is cut short and flagged.
      i_pll_locked <= 1'b1;
      repeat (5) @(posedge i_clk_sys);
      check({o_ring_osc_sel, o_stage}, {1'b0, 3'(ST_WAIT_CLK)});
      i_ref_clk_active <= 1'b1;
      wait_stage(ST_CONFIG, 10);
      apb(1'b0, ADDR_STATUS, 32'h0, 32'h264, 1'b0);
      wr(ADDR_SETUP, 2'b10, 1'b0);
      apb(1'b0, ADDR_SETUP, 32'h0, 32'h2, 1'b0);
      wait_stage(ST_CONNECT, CFG_N + 10);
      repeat (20) @(posedge i_clk_sys);
      check({28'h0, o_stage, o_upstream_dplus_pin}, {28'h0, 3'(ST_CONNECT), 1'b0});
      wr(ADDR_INTERLOCK, 2'b10, 1'b0);
      wait_stage(ST_COMM, 20);
      check({31'h0, o_upstream_dplus_pin}, 32'h1);
      tally_and_finish();
   end
   // Cuts a hang short well after the expected run length.
   initial begin
      repeat (5000) @(posedge i_clk_sys);
      mismatches++;
      tally_and_finish();
   end
endmodule // hub_mode_stage_sequencer_tb
